// ---- timer_pkg.sv ----
// Package with register map, field layout and reset values for the interval timer
//
// Behaviour
// R01: A 16-bit down-counter is decremented by one once every n clock cycles, n set by the prescale.
// R02: The 8-bit prescale setting holds n-1, so a stored k steps the counter once every k+1 cycles.
// R03: When the down-counter reaches zero a timer interrupt request is raised.
// R04: When the down-counter reaches zero it is reloaded from the 16-bit period setting.
// R05: The timer interrupt is individually maskable and reaches the processor only when its mask bit is set.
// R06: The prescaler is a cycle counter restarting from the stored scale value at each expiry, one step per expiry.
`default_nettype none
package timer_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_SCALE = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_PERIOD = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'hc;
  localparam int CNT_W = 16;
  localparam int SCL_W = 8;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MASK_BIT = 1;
  localparam int CTRL_STAT_BIT = 2;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [SCL_W-1:0] SCALE_RST = 8'h00;
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [CNT_W-1:0] value;
    logic wr;
  } cnt_load_t;
endpackage
`default_nettype wire

// ---- prescaler.sv ----
// Prescaler producing one step pulse every scale+1 cycles
`default_nettype none
module prescaler
  import timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [SCL_W-1:0] scale,
  output logic step
);
  logic [SCL_W-1:0] pre_r;

  assign step = run && (pre_r == '0); // R02

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= SCALE_RST;
    end else if (!run) begin
      pre_r <= scale;
    end else if (pre_r == '0) begin
      pre_r <= scale; // R06
    end else begin
      pre_r <= pre_r - 8'h01; // R06
    end
  end
endmodule
`default_nettype wire

// ---- interval_timer.sv ----
// Interval timer with AXI4-Lite register slave and masked interrupt
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none
module interval_timer
  import timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timer_irq
);
  logic [CNT_W-1:0] count_r;
  logic [SCL_W-1:0] scale_r;
  logic [CNT_W-1:0] period_r;
  logic en_r;
  logic mask_r;
  logic stat_r;
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic step;
  logic wr_go;
  logic rd_go;
  logic zero_evt;
  logic stat_rd;
  logic wr_ok;
  logic [1:0] wr_resp_nxt;
  logic sel_count;
  logic sel_scale;
  logic sel_period;
  logic sel_ctrl;
  logic [31:0] rd_data_nxt;
  logic [1:0] rd_resp_nxt;
  cnt_load_t sw_load;

  prescaler u_pre (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .run(en_r),
    .scale(scale_r),
    .step(step)
  );

  // Write channel: address and data taken in either order, both held until the response
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_r <= 1'b0;
    end
  end

  // Register selects for the held write; an unaligned address selects nothing
  assign wr_ok = (awaddr_r[1:0] == 2'h0);
  assign sel_count = wr_go && (awaddr_r == OFF_COUNT);
  assign sel_scale = wr_go && (awaddr_r == OFF_SCALE);
  assign sel_period = wr_go && (awaddr_r == OFF_PERIOD);
  assign sel_ctrl = wr_go && (awaddr_r == OFF_CTRL);
  assign wr_resp_nxt = wr_ok ? RESP_OKAY : RESP_SLVERR;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_resp_nxt;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scale_r <= SCALE_RST;
    end else if (sel_scale && wstrb_r[0]) begin
      scale_r <= wdata_r[SCL_W-1:0]; // R02
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      period_r <= PERIOD_RST;
    end else if (sel_period) begin
      if (wstrb_r[0]) begin
        period_r[7:0] <= wdata_r[7:0];
      end
      if (wstrb_r[1]) begin
        period_r[15:8] <= wdata_r[15:8];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_r <= 1'b0;
      mask_r <= 1'b0;
    end else if (sel_ctrl && wstrb_r[0]) begin
      en_r <= wdata_r[CTRL_EN_BIT];
      mask_r <= wdata_r[CTRL_MASK_BIT]; // R05
    end
  end

  // Software write into the live count; lanes left out keep the running value
  always_comb begin
    sw_load.wr = sel_count && (wstrb_r[1:0] != 2'h0);
    sw_load.value = count_r;
    if (wstrb_r[0]) begin
      sw_load.value[7:0] = wdata_r[7:0];
    end
    if (wstrb_r[1]) begin
      sw_load.value[15:8] = wdata_r[15:8];
    end
  end

  // A step that finds the count at zero reloads instead of wrapping
  assign zero_evt = step && (count_r == '0);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= COUNT_RST;
    end else if (sw_load.wr) begin
      count_r <= sw_load.value;
    end else if (zero_evt) begin
      count_r <= period_r; // R04
    end else if (step) begin
      count_r <= count_r - 16'h0001; // R01
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_go && (s_axi_araddr == OFF_CTRL);

  // Read data are chosen from the presented address and registered on acceptance
  always_comb begin
    rd_data_nxt = '0;
    rd_resp_nxt = RESP_OKAY;
    unique case (s_axi_araddr)
      OFF_COUNT: rd_data_nxt[CNT_W-1:0] = count_r;
      OFF_SCALE: rd_data_nxt[SCL_W-1:0] = scale_r;
      OFF_PERIOD: rd_data_nxt[CNT_W-1:0] = period_r;
      OFF_CTRL: begin
        rd_data_nxt[CTRL_EN_BIT] = en_r;
        rd_data_nxt[CTRL_MASK_BIT] = mask_r;
        rd_data_nxt[CTRL_STAT_BIT] = stat_r;
      end
      default: rd_resp_nxt = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data_nxt;
      s_axi_rresp <= rd_resp_nxt;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sticky status: a new event wins over the clear-on-read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_r <= 1'b0;
    end else if (zero_evt) begin
      stat_r <= 1'b1; // R03
    end else if (stat_rd) begin
      stat_r <= 1'b0;
    end
  end

  assign timer_irq = stat_r && mask_r; // R05
endmodule
`default_nettype wire

// ---- interval_timer_checker.sv ----
// Bus handshake and interrupt checker for the interval timer
`default_nettype none
module interval_timer_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while rvalid");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready while bvalid");
  a_irq_fall: assert property ($fell(timer_irq) |-> s_axi_rvalid || s_axi_bvalid)
    else $error("irq fell without access");
  cover property ($rose(timer_irq));
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind interval_timer interval_timer_checker i_chk (.*);
`default_nettype wire

// ---- interval_timer_tb.sv ----
// Self-checking bench for the interval timer
`default_nettype none
module interval_timer_tb import timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, irq_q = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, v, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, br;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_irq;
  int err_count = 0, samples_checked = 0, seed = 32'h62eb, cyc = 0, k, p;
  int rise[$];
  interval_timer i_dut (.*);
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    irq_q <= timer_irq;
    if (timer_irq && !irq_q) rise.push_back(cyc);
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t %h %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] x);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    s_axi_rready <= 0;
  endtask
  task automatic wi();
    for (int i = 0; i < 200 && !timer_irq; i++) @(posedge core_clk);
  endtask
  task automatic chk_idle();
    for (int i = 0; i < 4; i++) begin
      rd(4'(4 * i));
      chk(v, 32'h0000_0000);
      chk(s_axi_rresp, RESP_OKAY);
    end
    chk(timer_irq, 1'b0);
  endtask
  task automatic end_of_test();
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    chk_idle();
    for (int i = 0; i < 6; i++) begin
      d = $random(seed);
      wr(4'(4 * (i % 3)), d);
      chk(br, RESP_OKAY);
      rd(4'(4 * (i % 3)));
      chk(v, d & (i % 3 == 1 ? 32'h0000_00ff : 32'h0000_ffff));
      chk(s_axi_rresp, RESP_OKAY);
    end
    rd(4'h2);
    chk(v, 0);
    chk(s_axi_rresp, RESP_SLVERR);
    wr(4'h9, ~d);
    chk(br, RESP_SLVERR);
    rd(OFF_PERIOD);
    chk(v, d & 32'h0000_ffff);
    s_axi_wstrb <= 4'h2;
    wr(OFF_PERIOD, 32'h0000_a55a);
    s_axi_wstrb <= 4'hf;
    chk(br, RESP_OKAY);
    rd(OFF_PERIOD);
    chk(v, {16'h0000, 8'ha5, d[7:0]});
    k = $random(seed) & 3;
    p = 3 + ($random(seed) & 3);
    wr(OFF_SCALE, k);
    wr(OFF_PERIOD, p);
    wr(OFF_COUNT, 0);
    wr(OFF_CTRL, 3);
    repeat (3) begin
      wi();
      chk(timer_irq, 1);
      rd(OFF_CTRL);
      chk(v[2:0], 7);
    end
    chk(rise[1] - rise[0], (p + 1) * (k + 1));
    chk(rise[2] - rise[1], (p + 1) * (k + 1));
    wr(OFF_CTRL, 1);
    repeat (40) @(posedge core_clk);
    chk(timer_irq, 0);
    rd(OFF_CTRL);
    chk(v[2:0], 5);
    rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    chk_idle();
    end_of_test();
  end
endmodule
`default_nettype wire
